// >>> mde_pkg.sv
// Purpose: constants and types shared by the multiply/divide extension block
// Assumes: classic Wishbone, 32-bit data, registers one aligned word each
// Notes: register indices are byte address divided by four
// What this block does
// - after any reset, multiply and divide behave as classic 8-bit forms
// - 16-bit multiply or divide only when software sets its width bit
// - upper register supplies upper operand byte and takes upper result byte
// - 8-bit multiply: A times B, low byte to A, high byte to B
// - 16-bit multiply: low to A, middle to B, high to upper register
// - 8-bit divide: A over B, quotient into A
// - 16-bit divide: upper:A over B; quotient low A, remainder B, high upper
// - control bit 3 picks divide width, zero 8-bit, one 16-bit
// - two data pointers exist; toggling the select bit swaps the active one
// - pointer operations touch only the selected pointer, other stays unchanged
// - control bits 3, 2, 0 read/write, reset to zero; other bits unimplemented
// - control bit 2 picks multiply width, zero 8-bit, one 16-bit
// - select bit 0 zero picks standard pointer, one picks second pointer
package mde_pkg;

  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_DPL0 = 8'h82;
  localparam logic [7:0] IDX_DPH0 = 8'h83;
  localparam logic [7:0] IDX_DPL1 = 8'h84;
  localparam logic [7:0] IDX_DPH1 = 8'h85;
  localparam logic [7:0] IDX_CTRL = 8'h86;
  localparam logic [7:0] IDX_ACC = 8'hE0;
  localparam logic [7:0] IDX_B = 8'hF0;
  localparam logic [7:0] IDX_UPPER = 8'hF1;
  localparam logic [7:0] IDX_CMD = 8'hC0;
  localparam logic [7:0] IDX_STATUS = 8'hC1;
  localparam logic [7:0] IDX_ACTIVE_PTR = 8'hC2;

  // control register fields
  localparam int CTRL_PTR_SEL_BIT = 0;
  localparam int CTRL_MUL_WIDE_BIT = 2;
  localparam int CTRL_DIV_WIDE_BIT = 3;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h0D;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // command register fields (write-only strobes)
  localparam int CMD_MUL_BIT = 0;
  localparam int CMD_DIV_BIT = 1;
  localparam int CMD_PTR_INC_BIT = 2;

  // status register fields
  localparam int STAT_OV_BIT = 0;
  localparam int STAT_PTR_SEL_BIT = 1;

  // reset values of the data registers
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = {22'h0, idx, 2'b00};
  endfunction

  // request from the processor core, one-cycle strobes
  typedef struct packed {
    logic mul;
    logic div;
    logic ptr_inc;
    logic ptr_load;
    logic [15:0] ptr_val;
  } mde_core_req_s;

  // operand and result byte set of the arithmetic unit
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] upper;
    logic ov;
  } mde_arith_s;

endpackage

// >>> mde_arith.sv
// Purpose: combinational multiply/divide with 8-bit and 16-bit forms
// Assumes: width selects come straight from the control register
// Notes: divide by zero leaves all operands as they were and raises ov
`timescale 1ns/1ps
module mde_arith (
  // operands
  input wire mde_pkg::mde_arith_s opd_i,
  // width selects
  input wire logic mul_wide_i,
  input wire logic div_wide_i,
  // results
  output mde_pkg::mde_arith_s mul_res_o,
  output mde_pkg::mde_arith_s div_res_o
);

  logic [23:0] mul_opd;
  logic [23:0] product;
  logic [15:0] dividend;
  logic [15:0] quotient;
  logic [7:0] remainder;

  // multiply: upper byte joins the operand only in wide mode
  assign mul_opd = mul_wide_i ? {8'h00, opd_i.upper, opd_i.acc} : {16'h0000, opd_i.acc};
  assign product = mul_opd * {16'h0000, opd_i.b};

  always_comb begin
    mul_res_o.acc = product[7:0];
    mul_res_o.b = product[15:8];
    if (mul_wide_i) begin
      mul_res_o.upper = product[23:16];
      mul_res_o.ov = 1'b0;
    end else begin
      mul_res_o.upper = opd_i.upper;
      mul_res_o.ov = (product[15:8] != 8'h00);
    end
  end

  // divide: zero divisor is caught before the operators see it
  assign dividend = div_wide_i ? {opd_i.upper, opd_i.acc} : {8'h00, opd_i.acc};
  assign quotient = (opd_i.b == 8'h00) ? 16'h0000 : dividend / {8'h00, opd_i.b};
  assign remainder = (opd_i.b == 8'h00) ? 8'h00 : 8'(dividend % {8'h00, opd_i.b});

  always_comb begin
    if (opd_i.b == 8'h00) begin
      div_res_o = opd_i;
      div_res_o.ov = 1'b1;
    end else begin
      div_res_o.acc = quotient[7:0];
      div_res_o.b = remainder;
      div_res_o.upper = div_wide_i ? quotient[15:8] : opd_i.upper;
      div_res_o.ov = 1'b0;
    end
  end

endmodule // mde_arith

// >>> mde_core_ext.sv
// Purpose: 16-bit multiply/divide extension and dual data pointer
// Assumes: Wishbone classic slave, core strobes synchronous to clk_i
// Notes: core strobes take precedence over a bus write in the same cycle, except that a bus multiply command beats a core divide
`timescale 1ns/1ps
module mde_core_ext #(
  parameter int PTR_W = 16,
  parameter int NUM_PTR = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // processor core side
  input wire mde_pkg::mde_core_req_s core_req_i,
  output logic [15:0] active_ptr_o,
  output logic [7:0] acc_o,
  output logic [7:0] b_o,
  output logic [7:0] upper_o,
  output logic ov_o,
  // mode bits
  output logic mul_wide_o,
  output logic div_wide_o,
  output logic pointer_select_bit_o
);

  // elaboration check: logic is built for two 16-bit pointers
  if (PTR_W != 16 || NUM_PTR != 2) begin : g_bad_param
    $error("mde_core_ext supports only PTR_W=16 and NUM_PTR=2");
  end

  // elaboration check: the read-back mask must hold exactly the three mode bits
  if (mde_pkg::CTRL_IMPL_MASK != (8'h01 << mde_pkg::CTRL_PTR_SEL_BIT
      | 8'h01 << mde_pkg::CTRL_MUL_WIDE_BIT
      | 8'h01 << mde_pkg::CTRL_DIV_WIDE_BIT)) begin : g_bad_mask
    $error("mde_core_ext mode-bit mask does not match the field positions");
  end

  // elaboration check: reset may only set implemented control bits
  if ((mde_pkg::CTRL_RESET & ~mde_pkg::CTRL_IMPL_MASK) != 8'h00) begin : g_bad_reset
    $error("mde_core_ext control reset value sets unimplemented bits");
  end

  logic [7:0] instruction_extension_control;
  logic [7:0] acc;
  logic [7:0] b;
  logic [7:0] upper;
  logic ov;
  logic [15:0] dptr [NUM_PTR];
  logic bus_req;
  logic bus_wr;
  logic lane0_wr;
  logic lane1_wr;
  logic [31:0] next_dat;
  logic pointer_select_bit;
  logic mul_wide;
  logic div_wide;
  logic bus_mul;
  logic bus_div;
  logic bus_ptr_inc;
  logic do_mul;
  logic do_div;
  logic do_ptr_inc;
  logic do_ptr_load;
  logic [15:0] load_val;
  mde_pkg::mde_arith_s opd;
  mde_pkg::mde_arith_s mul_res;
  mde_pkg::mde_arith_s div_res;
  mde_pkg::mde_arith_s op_res;
  logic op_go;
  logic wr_ctrl;
  logic wr_acc;
  logic wr_b;
  logic wr_upper;
  logic wr_cmd;
  logic wr_active;

  // a bus access is taken in the cycle before ack, once per request
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr = bus_req & we_i;
  assign lane0_wr = bus_wr & sel_i[0];
  assign lane1_wr = bus_wr & sel_i[1];

  // one write strobe per byte register, all on the low lane
  assign wr_ctrl = lane0_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_CTRL);
  assign wr_acc = lane0_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_ACC);
  assign wr_b = lane0_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_B);
  assign wr_upper = lane0_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_UPPER);
  assign wr_cmd = lane0_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_CMD);
  // the active-pointer word takes either lane, qualified per lane at the pointer
  assign wr_active = bus_wr && adr_i == mde_pkg::reg_addr(mde_pkg::IDX_ACTIVE_PTR);

  // mode bits decoded from the control register
  assign pointer_select_bit = instruction_extension_control[mde_pkg::CTRL_PTR_SEL_BIT];
  assign mul_wide = instruction_extension_control[mde_pkg::CTRL_MUL_WIDE_BIT];
  assign div_wide = instruction_extension_control[mde_pkg::CTRL_DIV_WIDE_BIT];

  // software command strobes from the command register
  assign bus_mul = wr_cmd && dat_i[mde_pkg::CMD_MUL_BIT];
  assign bus_div = wr_cmd && dat_i[mde_pkg::CMD_DIV_BIT];
  assign bus_ptr_inc = wr_cmd && dat_i[mde_pkg::CMD_PTR_INC_BIT];

  // merged operation strobes; multiply wins if both are asked for
  assign do_mul = core_req_i.mul | bus_mul;
  assign do_div = (core_req_i.div | bus_div) & ~do_mul;
  assign op_go = do_mul | do_div;
  assign do_ptr_load = core_req_i.ptr_load;
  assign do_ptr_inc = (core_req_i.ptr_inc | bus_ptr_inc) & ~do_ptr_load;
  assign load_val = core_req_i.ptr_val;

  // operand bundle for the arithmetic unit
  assign opd.acc = acc;
  assign opd.b = b;
  assign opd.upper = upper;
  assign opd.ov = ov;

  mde_arith u_arith (
    .opd_i(opd),
    .mul_wide_i(mul_wide),
    .div_wide_i(div_wide),
    .mul_res_o(mul_res),
    .div_res_o(div_res)
  );

  // pick the result of the operation that runs this cycle
  assign op_res = do_mul ? mul_res : div_res;

  // instruction extension control: only bits 3, 2, 0 exist
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instruction_extension_control <= mde_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      instruction_extension_control <= dat_i[7:0] & mde_pkg::CTRL_IMPL_MASK;
    end
  end

  // accumulator: arithmetic result first, then a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= mde_pkg::BYTE_RESET;
    end else if (op_go) begin
      acc <= op_res.acc;
    end else if (wr_acc) begin
      acc <= dat_i[7:0];
    end
  end

  // b register: high or middle product byte, or remainder
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b <= mde_pkg::BYTE_RESET;
    end else if (op_go) begin
      b <= op_res.b;
    end else if (wr_b) begin
      b <= dat_i[7:0];
    end
  end

  // upper operand/result register, changed only by wide forms and bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper <= mde_pkg::BYTE_RESET;
    end else if (op_go) begin
      upper <= op_res.upper;
    end else if (wr_upper) begin
      upper <= dat_i[7:0];
    end
  end

  // overflow flag: narrow product above a byte or divide by zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov <= 1'b0;
    end else if (op_go) begin
      ov <= op_res.ov;
    end
  end

  // both data pointers; only the selected one follows core activity
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    logic selected;
    logic lo_hit;
    logic hi_hit;
    logic act_hit;

    assign selected = (pointer_select_bit == 1'(i));
    assign lo_hit = lane0_wr
      && adr_i == mde_pkg::reg_addr(i == 0 ? mde_pkg::IDX_DPL0 : mde_pkg::IDX_DPL1);
    assign hi_hit = lane0_wr
      && adr_i == mde_pkg::reg_addr(i == 0 ? mde_pkg::IDX_DPH0 : mde_pkg::IDX_DPH1);
    assign act_hit = selected && wr_active;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dptr[i] <= mde_pkg::PTR_RESET;
      end else if (selected && do_ptr_load) begin
        dptr[i] <= load_val;
      end else if (selected && do_ptr_inc) begin
        dptr[i] <= dptr[i] + 16'h0001;
      end else if (act_hit) begin
        if (lane0_wr) begin
          dptr[i][7:0] <= dat_i[7:0];
        end
        if (lane1_wr) begin
          dptr[i][15:8] <= dat_i[15:8];
        end
      end else begin
        if (lo_hit) begin
          dptr[i][7:0] <= dat_i[7:0];
        end
        if (hi_hit) begin
          dptr[i][15:8] <= dat_i[7:0]; // byte register sits on the low lane
        end
      end
    end
  end

  // read data selection, unmapped addresses read as zero
  always_comb begin
    next_dat = mde_pkg::WORD_ZERO;
    unique case (adr_i)
      mde_pkg::reg_addr(mde_pkg::IDX_DPL0): begin
        next_dat[7:0] = dptr[0][7:0];
      end
      mde_pkg::reg_addr(mde_pkg::IDX_DPH0): begin
        next_dat[7:0] = dptr[0][15:8];
      end
      mde_pkg::reg_addr(mde_pkg::IDX_DPL1): begin
        next_dat[7:0] = dptr[1][7:0];
      end
      mde_pkg::reg_addr(mde_pkg::IDX_DPH1): begin
        next_dat[7:0] = dptr[1][15:8];
      end
      mde_pkg::reg_addr(mde_pkg::IDX_CTRL): begin
        next_dat[7:0] = instruction_extension_control & mde_pkg::CTRL_IMPL_MASK;
      end
      mde_pkg::reg_addr(mde_pkg::IDX_ACC): begin
        next_dat[7:0] = acc;
      end
      mde_pkg::reg_addr(mde_pkg::IDX_B): begin
        next_dat[7:0] = b;
      end
      mde_pkg::reg_addr(mde_pkg::IDX_UPPER): begin
        next_dat[7:0] = upper;
      end
      mde_pkg::reg_addr(mde_pkg::IDX_STATUS): begin
        next_dat[mde_pkg::STAT_OV_BIT] = ov;
        next_dat[mde_pkg::STAT_PTR_SEL_BIT] = pointer_select_bit;
      end
      mde_pkg::reg_addr(mde_pkg::IDX_ACTIVE_PTR): begin
        next_dat[15:0] = dptr[pointer_select_bit];
      end
      default: begin
        next_dat = mde_pkg::WORD_ZERO;
      end
    endcase
  end

  // acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // read data is captured with a read request and held until the next read; writes leave it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= mde_pkg::WORD_ZERO;
    end else if (bus_req && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // core-facing outputs straight from the flops
  assign active_ptr_o = dptr[pointer_select_bit];
  assign acc_o = acc;
  assign b_o = b;
  assign upper_o = upper;
  assign ov_o = ov;
  assign mul_wide_o = mul_wide;
  assign div_wide_o = div_wide;
  assign pointer_select_bit_o = pointer_select_bit;

endmodule // mde_core_ext

// >>> mde_core_ext_checker.sv
// Purpose: port assertions for the multiply/divide extension block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by the bind after the module
`timescale 1ns/1ps
module mde_core_ext_checker #(
  parameter int PTR_W = 16,
  parameter int NUM_PTR = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // core side and mode bits
  input wire mde_pkg::mde_core_req_s core_req_i,
  input wire logic [15:0] active_ptr_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] b_o,
  input wire logic [7:0] upper_o,
  input wire logic ov_o,
  input wire logic mul_wide_o,
  input wire logic div_wide_o,
  input wire logic pointer_select_bit_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus request and its one-cycle answer
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  // divide request without a competing multiply
  sequence s_div(logic wide);
    core_req_i.div && !core_req_i.mul && div_wide_o == wide && b_o != 8'h00;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_ack_pulse)
    else $error("bus answer not a single pulse");
  a_reset_clear: assert property ($fell(rst_i) |->
    !mul_wide_o && !div_wide_o && !pointer_select_bit_o && ov_o == 1'b0)
    else $error("mode bits not clear after reset");
  a_mul_narrow: assert property (core_req_i.mul && !mul_wide_o |=>
    {b_o, acc_o} == $past(acc_o) * $past(b_o) && upper_o == $past(upper_o))
    else $error("narrow multiply result wrong");
  a_mul_wide: assert property (core_req_i.mul && mul_wide_o |=>
    {upper_o, b_o, acc_o} == {$past(upper_o), $past(acc_o)} * $past(b_o))
    else $error("wide multiply result wrong");
  a_div_narrow: assert property (s_div(1'b0) |=> acc_o == $past(acc_o) / $past(b_o)
    && b_o == $past(acc_o) % $past(b_o) && $stable(upper_o))
    else $error("narrow divide result wrong");
  a_div_wide: assert property (s_div(1'b1) |=>
    {upper_o, acc_o} == {$past(upper_o), $past(acc_o)} / $past(b_o)
    && b_o == {$past(upper_o), $past(acc_o)} % $past(b_o))
    else $error("wide divide quotient wrong");
  a_div_zero: assert property (core_req_i.div && !core_req_i.mul && b_o == 8'h00 |=>
    $stable(acc_o) && $stable(upper_o) && ov_o)
    else $error("divide by zero altered operands");
  a_ptr_load: assert property (core_req_i.ptr_load |=>
    active_ptr_o == $past(core_req_i.ptr_val))
    else $error("pointer load wrong");
  a_ptr_inc: assert property (core_req_i.ptr_inc && !core_req_i.ptr_load |=>
    active_ptr_o == $past(active_ptr_o) + 16'h0001)
    else $error("pointer increment wrong");
endmodule // mde_core_ext_checker

bind mde_core_ext mde_core_ext_checker #(.PTR_W(PTR_W), .NUM_PTR(NUM_PTR)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .core_req_i(core_req_i), .active_ptr_o(active_ptr_o), .acc_o(acc_o), .b_o(b_o),
  .upper_o(upper_o), .ov_o(ov_o), .mul_wide_o(mul_wide_o), .div_wide_o(div_wide_o),
  .pointer_select_bit_o(pointer_select_bit_o));

// >>> tb_top.sv
// Purpose: self-checking bench for the multiply/divide extension block
// Assumes: classic Wishbone master, core strobes one cycle wide
// Notes: operands from a fixed-seed xorshift with corner cases first
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, ov_o;
  logic mul_wide_o, div_wide_o, pointer_select_bit_o;
  logic [31:0] adr_i, dat_i, dat_o, rd, r, k;
  logic [3:0] sel_i;
  logic [15:0] active_ptr_o;
  logic [7:0] acc_o, b_o, upper_o, a, b, u;
  mde_pkg::mde_core_req_s core_req_i;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h7D95;

  mde_core_ext #(.PTR_W(16), .NUM_PTR(2)) u_mde_core_ext (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .core_req_i(core_req_i), .active_ptr_o(active_ptr_o), .acc_o(acc_o), .b_o(b_o),
    .upper_o(upper_o), .ov_o(ov_o), .mul_wide_o(mul_wide_o), .div_wide_o(div_wide_o),
    .pointer_select_bit_o(pointer_select_bit_o));

  // clock source
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {upper, b, acc} after an operation
  function automatic logic [23:0] calc(input logic m, input logic w, input logic [7:0] a,
                                       input logic [7:0] b, input logic [7:0] u);
    logic [15:0] n, q, rm;
    n = w ? {u, a} : {8'h00, a};
    if (m)
      return w ? 24'(n) * 24'(b) : {u, n * {8'h00, b}};
    if (b == 8'h00)
      return {u, b, a};
    q = n / {8'h00, b};
    rm = n % {8'h00, b};
    return {w ? q[15:8] : u, rm[7:0], q[7:0]};
  endfunction

  // expected overflow flag after an operation
  function automatic logic exp_ov(input logic m, input logic w, input logic [7:0] a,
                                  input logic [7:0] b);
    if (m)
      return !w && ({8'h00, a} * {8'h00, b}) > 16'h00FF;
    return b == 8'h00;
  endfunction

  // one classic bus cycle, waits for ack; only the hang guard ends a wait
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {22'h0, idx, 2'b00};
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // one core strobe cycle
  task automatic op(input logic m, input logic dv, input logic inc, input logic ld,
                    input logic [15:0] v);
    @(posedge clk_i);
    core_req_i <= {m, dv, inc, ld, v};
    @(posedge clk_i);
    core_req_i <= '0;
    #1;
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'b000;
    {adr_i, dat_i} = 64'h0;
    sel_i = 4'h0;
    core_req_i = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, mde_pkg::IDX_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    `CHK({mul_wide_o, div_wide_o, pointer_select_bit_o}, 3'b000)
    wb(1'b1, mde_pkg::IDX_CTRL, 32'hFF);
    wb(1'b0, mde_pkg::IDX_CTRL, 32'h0);
    `CHK(rd, 32'h0D)
    `CHK({mul_wide_o, div_wide_o, pointer_select_bit_o}, 3'b111)
    wb(1'b0, 8'h90, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, mde_pkg::IDX_CTRL, 32'h0);
    op(1'b0, 1'b0, 1'b0, 1'b1, 16'h1234);
    wb(1'b1, mde_pkg::IDX_CTRL, 32'h1);
    `CHK(active_ptr_o, 16'h0000)
    op(1'b0, 1'b0, 1'b0, 1'b1, 16'hABFF);
    op(1'b0, 1'b0, 1'b1, 1'b0, 16'h0);
    `CHK(active_ptr_o, 16'hAC00)
    wb(1'b0, mde_pkg::IDX_DPH1, 32'h0);
    `CHK(rd, 32'hAC)
    wb(1'b1, mde_pkg::IDX_CTRL, 32'h0);
    `CHK(active_ptr_o, 16'h1234)
    wb(1'b0, mde_pkg::IDX_DPL0, 32'h0);
    `CHK(rd, 32'h34)
    wb(1'b1, mde_pkg::IDX_CMD, 32'h4);
    wb(1'b0, mde_pkg::IDX_ACTIVE_PTR, 32'h0);
    `CHK(rd, 32'h1235)
    wb(1'b0, mde_pkg::IDX_DPL1, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, mde_pkg::IDX_ACTIVE_PTR, 32'h5A6B);
    `CHK(active_ptr_o, 16'h5A6B)
    wb(1'b1, mde_pkg::IDX_CTRL, 32'h1);
    wb(1'b0, mde_pkg::IDX_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(active_ptr_o, 16'hAC00)
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      k = rnd();
      {u, b, a} = r[23:0];
      if (i == 0)
        {b, k[2]} = 9'h0;
      if (i == 1)
        {u, b, a} = 24'hFFFFFF;
      if (i == 2)
        b = 8'h01;
      wb(1'b1, mde_pkg::IDX_ACC, {24'h0, a});
      wb(1'b1, mde_pkg::IDX_B, {24'h0, b});
      wb(1'b1, mde_pkg::IDX_UPPER, {24'h0, u});
      wb(1'b1, mde_pkg::IDX_CTRL, {28'h0, k[1:0], 2'b00});
      `CHK({div_wide_o, mul_wide_o}, k[1:0])
      if (k[4])
        wb(1'b1, mde_pkg::IDX_CMD, {30'h0, k[3] | ~k[2], k[2]});
      else
        op(k[2], k[3] | ~k[2], 1'b0, 1'b0, 16'h0);
      `CHK({upper_o, b_o, acc_o}, calc(k[2], k[2] ? k[0] : k[1], a, b, u))
      `CHK(ov_o, exp_ov(k[2], k[0], a, b))
    end
    wb(1'b1, mde_pkg::IDX_CTRL, 32'hD);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({upper_o, b_o, acc_o, ov_o, active_ptr_o}, 41'h0)
    wb(1'b0, mde_pkg::IDX_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    `CHK({mul_wide_o, div_wide_o, pointer_select_bit_o}, 3'b000)
    wb(1'b1, mde_pkg::IDX_ACC, 32'h12);
    wb(1'b1, mde_pkg::IDX_B, 32'h34);
    wb(1'b1, mde_pkg::IDX_UPPER, 32'h56);
    op(1'b1, 1'b0, 1'b0, 1'b0, 16'h0);
    `CHK({upper_o, b_o, acc_o}, 24'h5603A8)
    `CHK(ov_o, 1'b1)
    wb(1'b1, mde_pkg::IDX_DPH1, 32'h7E);
    wb(1'b1, mde_pkg::IDX_DPL0, 32'hC3);
    `CHK(active_ptr_o, 16'h00C3)
    wb(1'b0, mde_pkg::IDX_DPH1, 32'h0);
    `CHK(rd, 32'h7E)
    complete_run();
  end
endmodule // tb_top
